// *** umc_params.svh ***
// constants of the serial port mode-control block: offsets, fields, resets, counts
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// register byte offsets on the bus
`define UMC_OFS_MODE 8'h00
`define UMC_OFS_STAT 8'h04
`define UMC_OFS_MASK 8'h08
`define UMC_OFS_MEAS 8'h0C

// mode register fields
`define UMC_MODE_W 16
`define UMC_MODE_RST 16'h0000
`define UMC_MODE_WMASK 16'hBBFF
`define UMC_BIT_EN 15
`define UMC_BIT_INFRARED_CODEC_ENABLE 12
`define UMC_BIT_UEN_HI 9
`define UMC_BIT_UEN_LO 8
`define UMC_BIT_WAKE 7
`define UMC_BIT_LOOP 6
`define UMC_BIT_AUTO_BAUD_ENABLE 5
`define UMC_BIT_HIGH_SPEED_BAUD_SELECT 3

// pin usage codes
`define UMC_UEN_TXRX 2'h0
`define UMC_UEN_RTS 2'h1
`define UMC_UEN_FLOW 2'h2
`define UMC_UEN_BCLK 2'h3

// pin indices of the four port pins; the last is shared by request-to-send and baud clock
`define UMC_PIN_N 4
`define UMC_PIN_TX 0
`define UMC_PIN_RX 1
`define UMC_PIN_CTS 2
`define UMC_PIN_RTS 3

// event status and mask bits
`define UMC_STAT_W 2
`define UMC_STAT_RST 2'h0
`define UMC_EV_WAKE 0
`define UMC_EV_AUTO_BAUD_ENABLE 1

// infrared codec, counted in ticks of the 16x baud clock
`define UMC_IR_PULSE_TICKS 4'h3
`define UMC_IR_BIT_TICKS 5'h10

// baud measurement: four falling edges after the start edge span eight bits of a 55h field
`define UMC_MEAS_W 16
`define UMC_MEAS_RST 16'h0000
`define UMC_AB_FALLS 3'h4
`define UMC_AB_SHIFT 3

`endif

// *** umc_pkg.sv ***
// types of the serial port mode-control block
`include "umc_params.svh"

package umc_pkg;

	typedef enum logic [1:0]
	{
		UMC_AB_IDLE = 2'h0,
		UMC_AB_ARM = 2'h1,
		UMC_AB_MEAS = 2'h3
	} umc_ab_state_t;

	typedef struct packed
	{
		logic [`UMC_MODE_W-1:0] mode;
		logic [`UMC_STAT_W-1:0] stat;
		logic [`UMC_STAT_W-1:0] mask;
		logic [`UMC_MEAS_W-1:0] meas;
		logic [`UMC_MEAS_W-1:0] cnt;
		logic [2:0] falls;
		logic prev_rx;
		logic prev_pin;
		logic wake_seen;
		umc_ab_state_t ab;
		logic ack;
		logic [31:0] dat;
	} umc_state_t;

	typedef struct packed
	{
		logic [3:0] enc_phase;
		logic prev_tx;
		logic [4:0] dec_cnt;
	} umc_mux_state_t;

endpackage

// *** umc_pin_mux.sv ***
// pin ownership, infrared codec and loopback routing of the serial port
`timescale 1ns/100ps
`include "umc_params.svh"

module umc_pin_mux
	import umc_pkg::*;
(
	input wire logic clk_in, // core clock
	input wire logic arst_n_in, // async reset, active low
	input wire logic en_in, // port enable
	input wire logic [1:0] uen_in, // pin usage select
	input wire logic infrared_codec_enable_in, // infrared codec enable
	input wire logic high_speed_baud_select_in, // high speed baud select
	input wire logic loop_in, // loopback select
	input wire logic tick16_in, // 16x baud tick
	input wire logic core_tx_in, // transmitter serial data
	input wire logic core_rts_in, // request-to-send from flow control
	input wire logic bclk_in, // baud clock output level
	input wire logic [`UMC_PIN_N-1:0] pin_in, // pad input levels
	input wire logic [`UMC_PIN_N-1:0] latch_out_in, // port latch output levels
	input wire logic [`UMC_PIN_N-1:0] latch_oe_in, // port latch output enables
	output logic [`UMC_PIN_N-1:0] pin_out_out, // pad output levels
	output logic [`UMC_PIN_N-1:0] pin_oe_out, // pad output enables
	output logic rx_to_core_out, // receive data toward the receiver
	output logic cts_to_core_out // clear-to-send toward the transmitter
);

	umc_mux_state_t st;
	umc_mux_state_t next_st;
	logic ir_on;
	logic ir_tx;
	logic tx_line;
	logic rx_line;

	////////////////////////////////////////////////////////////////////////////
	// codec runs only in 16x mode; elsewhere it is held at zero to save power
	assign ir_on = en_in && infrared_codec_enable_in && !high_speed_baud_select_in;

	// encoder phase restarts on each falling data edge; decoder stretches a pulse to one bit
	always_comb
	begin
		next_st = st;
		next_st.prev_tx = core_tx_in;
		if (st.prev_tx && !core_tx_in)
			next_st.enc_phase = '0;
		else if (tick16_in)
			next_st.enc_phase = st.enc_phase + 4'h1;
		if (pin_in[`UMC_PIN_RX])
			next_st.dec_cnt = `UMC_IR_BIT_TICKS;
		else if (tick16_in && st.dec_cnt != 5'h00)
			next_st.dec_cnt = st.dec_cnt - 5'h01;
		if (!ir_on)
			next_st = '0;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// a zero bit becomes a short high pulse; the idle infrared line is low
	assign ir_tx = !core_tx_in && (st.enc_phase < `UMC_IR_PULSE_TICKS);
	assign tx_line = ir_on ? ir_tx : core_tx_in;
	assign rx_line = ir_on ? (st.dec_cnt == 5'h00) : pin_in[`UMC_PIN_RX];
	assign rx_to_core_out = !en_in ? 1'b1 : (loop_in ? core_tx_in : rx_line);
	assign cts_to_core_out = en_in && uen_in == `UMC_UEN_FLOW && pin_in[`UMC_PIN_CTS];

	// pins not claimed by the chosen usage stay with the port latches
	always_comb
	begin
		pin_out_out = latch_out_in;
		pin_oe_out = latch_oe_in;
		if (en_in)
		begin
			pin_out_out[`UMC_PIN_TX] = tx_line;
			pin_oe_out[`UMC_PIN_TX] = 1'b1;
			pin_out_out[`UMC_PIN_RX] = 1'b0;
			pin_oe_out[`UMC_PIN_RX] = 1'b0;
			unique case (uen_in)
				`UMC_UEN_TXRX:
				begin
				end
				`UMC_UEN_RTS:
				begin
					pin_out_out[`UMC_PIN_RTS] = core_rts_in;
					pin_oe_out[`UMC_PIN_RTS] = 1'b1;
				end
				`UMC_UEN_FLOW:
				begin
					pin_out_out[`UMC_PIN_CTS] = 1'b0;
					pin_oe_out[`UMC_PIN_CTS] = 1'b0;
					pin_out_out[`UMC_PIN_RTS] = core_rts_in;
					pin_oe_out[`UMC_PIN_RTS] = 1'b1;
				end
				`UMC_UEN_BCLK:
				begin
					pin_out_out[`UMC_PIN_RTS] = bclk_in;
					pin_oe_out[`UMC_PIN_RTS] = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks on the routing
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	latch_pins_a: assert property (!en_in |-> pin_out_out == latch_out_in && pin_oe_out == latch_oe_in)
		else $error("disabled port does not leave pins to latches");
	rts_owned_a: assert property (en_in && uen_in == `UMC_UEN_RTS |->
		pin_oe_out[`UMC_PIN_RTS] && pin_out_out[`UMC_PIN_RTS] == core_rts_in
		&& pin_oe_out[`UMC_PIN_CTS] == latch_oe_in[`UMC_PIN_CTS])
		else $error("rts usage routed wrongly");
	bclk_pin_a: assert property (en_in && uen_in == `UMC_UEN_BCLK |->
		pin_out_out[`UMC_PIN_RTS] == bclk_in && pin_out_out[`UMC_PIN_CTS] == latch_out_in[`UMC_PIN_CTS])
		else $error("baud clock usage routed wrongly");
	ir_gated_a: assert property (en_in && high_speed_baud_select_in |-> pin_out_out[`UMC_PIN_TX] == core_tx_in)
		else $error("infrared codec active outside 16x mode");
	// the phase register clears one edge after the codec is switched off
	ir_idle_a: assert property (en_in && high_speed_baud_select_in |=> st.enc_phase == 4'h0)
		else $error("infrared encoder phase not cleared outside 16x mode");
	loop_rx_a: assert property (en_in && loop_in |-> rx_to_core_out == core_tx_in)
		else $error("loopback does not return transmit data");
	ir_pulse_c: cover property (ir_on && pin_out_out[`UMC_PIN_TX] ##1 !pin_out_out[`UMC_PIN_TX]);

endmodule // umc_pin_mux

// *** umc_mode_ctrl.sv ***
// serial port mode control: wishbone registers, pin usage, wake on start, baud measurement
// Overview of operation
// - enabled port owns pins per usage select; disabled, latches own pins, logic idles
// - usage 00 tx/rx, 01 adds rts, 10 adds cts and rts, 11 adds baud clock
// - infrared codec works only in 16x mode, high speed baud select clear
// - wake in sleep: sample rx, interrupt on fall, self-clear on next rise
// - loopback select routes own transmit data to receiver; clear means no loopback
`timescale 1ns/100ps
`include "umc_params.svh"

module umc_mode_ctrl
	import umc_pkg::*;
(
	input wire logic clk_in, // 250 MHz core clock
	input wire logic arst_n_in, // async reset, active low
	input wire logic wb_cyc_in, // wishbone cycle
	input wire logic wb_stb_in, // wishbone strobe
	input wire logic wb_we_in, // wishbone write
	input wire logic [7:0] wb_adr_in, // wishbone byte address
	input wire logic [3:0] wb_sel_in, // wishbone byte selects
	input wire logic [31:0] wb_dat_in, // wishbone write data
	output logic [31:0] wb_dat_out, // wishbone read data
	output logic wb_ack_out, // wishbone acknowledge
	output logic irq_out, // level interrupt
	input wire logic sleep_in, // device is in sleep
	input wire logic tick16_in, // 16x baud tick
	input wire logic core_tx_in, // transmitter serial data
	input wire logic core_rts_in, // request-to-send from flow control
	input wire logic bclk_in, // baud clock output level
	output logic core_rx_out, // receive data toward the receiver
	output logic core_cts_out, // clear-to-send toward the transmitter
	output logic [`UMC_MODE_W-1:0] mode_out, // mode register for the datapath
	output logic [`UMC_MEAS_W-1:0] baud_meas_out, // measured bit period in cycles
	input wire logic [`UMC_PIN_N-1:0] pin_in, // pad input levels
	input wire logic [`UMC_PIN_N-1:0] latch_out_in, // port latch output levels
	input wire logic [`UMC_PIN_N-1:0] latch_oe_in, // port latch output enables
	output logic [`UMC_PIN_N-1:0] pin_out_out, // pad output levels
	output logic [`UMC_PIN_N-1:0] pin_oe_out // pad output enables
);

	umc_state_t st;
	umc_state_t next_st;
	logic en;
	logic req;
	logic wr;
	logic rx_core;
	logic rx_pin;
	logic wake_fall;
	logic wake_rise;
	logic ab_fall;
	logic [`UMC_MEAS_W-1:0] cnt_inc;

	////////////////////////////////////////////////////////////////////////////
	// pin routing and codec
	assign en = st.mode[`UMC_BIT_EN];

	umc_pin_mux u_mux
	(
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.en_in(en),
		.uen_in(st.mode[`UMC_BIT_UEN_HI:`UMC_BIT_UEN_LO]),
		.infrared_codec_enable_in(st.mode[`UMC_BIT_INFRARED_CODEC_ENABLE]),
		.high_speed_baud_select_in(st.mode[`UMC_BIT_HIGH_SPEED_BAUD_SELECT]),
		.loop_in(st.mode[`UMC_BIT_LOOP]),
		.tick16_in(tick16_in),
		.core_tx_in(core_tx_in),
		.core_rts_in(core_rts_in),
		.bclk_in(bclk_in),
		.pin_in(pin_in),
		.latch_out_in(latch_out_in),
		.latch_oe_in(latch_oe_in),
		.pin_out_out(pin_out_out),
		.pin_oe_out(pin_oe_out),
		.rx_to_core_out(rx_core),
		.cts_to_core_out(core_cts_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// edge detection; wake looks at the raw pad, measurement at what the receiver sees
	assign rx_pin = pin_in[`UMC_PIN_RX];
	assign req = wb_cyc_in && wb_stb_in;
	assign wr = req && wb_we_in && st.ack;
	assign wake_fall = en && sleep_in && st.mode[`UMC_BIT_WAKE] && st.prev_pin && !rx_pin;
	assign wake_rise = en && sleep_in && st.mode[`UMC_BIT_WAKE] && st.wake_seen && !st.prev_pin && rx_pin;
	assign ab_fall = st.prev_rx && !rx_core;
	assign cnt_inc = st.cnt + `UMC_MEAS_W'(1);

	// one process computes every next value; bus writes to mode override hardware clears
	always_comb
	begin
		next_st = st;
		next_st.prev_rx = rx_core;
		next_st.prev_pin = rx_pin;

		// wake on start bit: flag on the fall, drop the enable on the following rise
		if (wake_fall)
		begin
			next_st.stat[`UMC_EV_WAKE] = 1'b1;
			next_st.wake_seen = 1'b1;
		end
		if (wake_rise)
		begin
			next_st.mode[`UMC_BIT_WAKE] = 1'b0;
			next_st.wake_seen = 1'b0;
		end
		if (!st.mode[`UMC_BIT_WAKE])
			next_st.wake_seen = 1'b0;

		// baud measurement; counter saturates rather than wrap on a line that never toggles
		unique case (st.ab)
			UMC_AB_IDLE:
			begin
				if (en && st.mode[`UMC_BIT_AUTO_BAUD_ENABLE])
					next_st.ab = UMC_AB_ARM;
			end
			UMC_AB_ARM:
			begin
				if (ab_fall)
				begin
					next_st.ab = UMC_AB_MEAS;
					next_st.cnt = '0;
					next_st.falls = '0;
				end
			end
			UMC_AB_MEAS:
			begin
				if (cnt_inc != '0)
					next_st.cnt = cnt_inc;
				if (ab_fall)
				begin
					next_st.falls = st.falls + 3'h1;
					if (st.falls + 3'h1 == `UMC_AB_FALLS)
					begin
						next_st.meas = cnt_inc >> `UMC_AB_SHIFT;
						next_st.mode[`UMC_BIT_AUTO_BAUD_ENABLE] = 1'b0;
						next_st.stat[`UMC_EV_AUTO_BAUD_ENABLE] = 1'b1;
						next_st.ab = UMC_AB_IDLE;
					end
				end
			end
			default:
				next_st.ab = UMC_AB_IDLE;
		endcase
		if (!en || !st.mode[`UMC_BIT_AUTO_BAUD_ENABLE])
		begin
			next_st.ab = UMC_AB_IDLE;
			next_st.cnt = '0;
			next_st.falls = '0;
		end

		// bus slave: ack one cycle after the request, writes land on the ack edge
		next_st.ack = req && !st.ack;
		next_st.dat = '0;
		if (req && !st.ack && !wb_we_in)
		begin
			unique case (wb_adr_in)
				`UMC_OFS_MODE: next_st.dat = 32'(st.mode);
				`UMC_OFS_STAT: next_st.dat = 32'(st.stat);
				`UMC_OFS_MASK: next_st.dat = 32'(st.mask);
				`UMC_OFS_MEAS: next_st.dat = 32'(st.meas);
				default: next_st.dat = '0;
			endcase
		end
		if (wr)
		begin
			unique case (wb_adr_in)
				`UMC_OFS_MODE:
				begin
					if (wb_sel_in[0])
						next_st.mode[7:0] = wb_dat_in[7:0];
					if (wb_sel_in[1])
						next_st.mode[15:8] = wb_dat_in[15:8] & 8'(`UMC_MODE_WMASK >> 8);
				end
				`UMC_OFS_STAT:
				begin
					// the clear reaches only bits already set, so a hardware set of a clear bit in the same cycle wins
					if (wb_sel_in[0])
						next_st.stat = next_st.stat & ~(st.stat & wb_dat_in[`UMC_STAT_W-1:0]);
				end
				`UMC_OFS_MASK:
				begin
					if (wb_sel_in[0])
						next_st.mask = wb_dat_in[`UMC_STAT_W-1:0];
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st <= '0;
			st.mode <= `UMC_MODE_RST;
			st.stat <= `UMC_STAT_RST;
			st.mask <= `UMC_STAT_RST;
			st.meas <= `UMC_MEAS_RST;
			st.prev_rx <= 1'b1;
			st.prev_pin <= 1'b1;
			st.ab <= UMC_AB_IDLE;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign wb_ack_out = st.ack;
	assign wb_dat_out = st.dat;
	assign irq_out = |(st.stat & st.mask);
	assign mode_out = st.mode;
	assign baud_meas_out = st.meas;
	assign core_rx_out = rx_core;

	////////////////////////////////////////////////////////////////////////////
	// checks on wake, baud measurement, bus acknowledge and loopback
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	wake_irq_a: assert property (wake_fall && st.mask[`UMC_EV_WAKE] |=> st.stat[`UMC_EV_WAKE] && irq_out)
		else $error("falling rx edge in sleep did not raise wake interrupt");
	wake_clear_a: assert property (wake_rise && !wr |=> !st.mode[`UMC_BIT_WAKE] && !st.wake_seen)
		else $error("wake enable not cleared on following rising edge");
	wake_hold_a: assert property (en && sleep_in && st.mode[`UMC_BIT_WAKE] && !st.wake_seen && rx_pin && !wr
		|=> st.mode[`UMC_BIT_WAKE])
		else $error("wake enable dropped without an edge pair");
	auto_baud_enable_done_a: assert property (st.ab == UMC_AB_MEAS && ab_fall && st.falls == 3'h3 && !wr
		|=> !st.mode[`UMC_BIT_AUTO_BAUD_ENABLE] && st.stat[`UMC_EV_AUTO_BAUD_ENABLE] && st.ab == UMC_AB_IDLE
		&& st.meas == ($past(cnt_inc) >> `UMC_AB_SHIFT))
		else $error("baud measurement did not complete correctly");
	auto_baud_enable_arm_a: assert property (st.ab == UMC_AB_ARM && !ab_fall && en && st.mode[`UMC_BIT_AUTO_BAUD_ENABLE] && !wr
		|=> st.ab == UMC_AB_ARM)
		else $error("measurement left arming without a start edge");
	disabled_idle_a: assert property (!en |=> st.ab == UMC_AB_IDLE && st.cnt == '0)
		else $error("disabled port keeps measuring");
	bus_ack_a: assert property (req && !st.ack |=> wb_ack_out ##1 !wb_ack_out)
		else $error("bus ack not a single cycle after request");
	auto_baud_enable_c: cover property (st.ab == UMC_AB_MEAS ##[1:1000] st.stat[`UMC_EV_AUTO_BAUD_ENABLE]);
	wake_c: cover property (wake_fall ##[1:1000] wake_rise);
	loop_c: cover property (en && st.mode[`UMC_BIT_LOOP] && !core_tx_in);

endmodule // umc_mode_ctrl

// *** umc_remote.sv ***
// model of the remote serial device on the receive and clear-to-send lines
`timescale 1ns/100ps

module umc_remote
(
	input wire logic clk_in, // bench clock
	output logic rx_out, // line toward the port receive pin
	output logic cts_out // clear-to-send level toward the port
);
	// the line idles high between characters, so no stale data level lingers
	initial
	begin
		rx_out = 1'h1;
		cts_out = 1'h1;
	end

	// one level change, launched just after a rising edge
	task automatic set_rx(input logic v);
		@(posedge clk_in);
		rx_out <= v;
	endtask

	// start bit, eight data bits lsb first, stop bit; a 55h gives the sync field
	task automatic send_byte(input logic [7:0] b, input int period);
		logic [9:0] frame;
		frame = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			set_rx(frame[i]);
			repeat (period - 1) @(posedge clk_in);
		end
	endtask
endmodule // umc_remote

// *** umc_mode_ctrl_tb.sv ***
// self-checking bench of the serial port mode-control block
`timescale 1ns/100ps
`include "umc_params.svh"

module umc_mode_ctrl_tb;
	import umc_pkg::*;

	typedef struct packed
	{
		logic [15:0] mode;
		logic tx;
		logic rts;
		logic bclk;
		logic chk_rx;
		logic [3:0] oe;
		logic [3:0] out;
		logic rx;
		logic cts;
	} umc_row_t;

	localparam logic [15:0] BIT_CYC = 16'h0028;
	logic clk_in = 1'h0;
	logic arst_n, wb_cyc, wb_stb, wb_we, sleep, tick16, core_tx, core_rts, bclk;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel, latch_out, latch_oe, pin_out, pin_oe, pad, tcnt;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic ack, irq, core_rx, core_cts, rx_line, cts_line;
	logic [15:0] mode_port, meas;
	int errors = 0;
	int checks_done = 0;
	umc_row_t rows [8] = '{
		'{16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 4'hF, 4'hF, 1'h1, 1'h0},
		'{16'h8000, 1'h1, 1'h0, 1'h1, 1'h1, 4'hD, 4'hD, 1'h1, 1'h0},
		'{16'h8100, 1'h1, 1'h0, 1'h1, 1'h1, 4'hD, 4'h5, 1'h1, 1'h0},
		'{16'h8200, 1'h1, 1'h0, 1'h1, 1'h1, 4'h9, 4'h1, 1'h1, 1'h1},
		'{16'h8300, 1'h1, 1'h1, 1'h0, 1'h1, 4'hD, 4'h5, 1'h1, 1'h0},
		'{16'h8040, 1'h0, 1'h0, 1'h0, 1'h1, 4'hD, 4'hC, 1'h0, 1'h0},
		'{16'h9000, 1'h1, 1'h0, 1'h0, 1'h0, 4'hD, 4'hC, 1'h1, 1'h0},
		'{16'h9008, 1'h1, 1'h0, 1'h0, 1'h1, 4'hD, 4'hD, 1'h1, 1'h0}
	};

	// 4 ns period; the 16x tick pulses every fourth cycle
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		tcnt <= tcnt + 4'h1;
		tick16 <= (tcnt[1:0] == 2'h3);
	end

	// pad levels: a pin nobody drives floats to its pull-up
	assign pad = {pin_oe[3] ? pin_out[3] : 1'h1, pin_oe[2] ? pin_out[2] : cts_line,
		pin_oe[1] ? pin_out[1] : rx_line, pin_oe[0] ? pin_out[0] : 1'h1};

	umc_remote i_remote (.clk_in(clk_in), .rx_out(rx_line), .cts_out(cts_line));

	umc_mode_ctrl i_dut (.clk_in(clk_in), .arst_n_in(arst_n), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
		.wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
		.wb_ack_out(ack), .irq_out(irq), .sleep_in(sleep), .tick16_in(tick16), .core_tx_in(core_tx),
		.core_rts_in(core_rts), .bclk_in(bclk), .core_rx_out(core_rx), .core_cts_out(core_cts),
		.mode_out(mode_port), .baud_meas_out(meas), .pin_in(pad), .latch_out_in(latch_out),
		.latch_oe_in(latch_oe), .pin_out_out(pin_out), .pin_oe_out(pin_oe));

	////////////////////////////////////////////////////////////////////////////////
	// one classic cycle; request held until ack is sampled high, then released
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdv);
		int n;
		@(posedge clk_in);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (ack !== 1'h1 && n < 50);
		if (n >= 50)
			errors++;
		rdv = wb_rdat;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		wb_we <= 1'h0;
	endtask

	task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp1(input string name, input logic exp, input logic got);
		cmp16(name, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic wr(input logic [7:0] adr, input logic [15:0] v);
		wb_cycle(1'h1, adr, {16'h0000, v}, rd);
		// let the write edge settle before any output is compared
		@(posedge clk_in);
	endtask

	task automatic chk_rd(input string name, input logic [7:0] adr, input logic [15:0] exp);
		wb_cycle(1'h0, adr, 32'h0, rd);
		cmp16(name, exp, rd[15:0]);
	endtask

	task automatic conclude();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// cut a hang short well beyond the few thousand nanoseconds the tests need
	initial
	begin
		#200000;
		errors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{arst_n, wb_cyc, wb_stb, wb_we, sleep, core_rts, bclk, tcnt, tick16} = '0;
		{wb_adr, wb_wdat} = '0;
		wb_sel = 4'hF;
		core_tx = 1'h1;
		latch_out = 4'hF;
		latch_oe = 4'hF;
		repeat (20) @(posedge clk_in);
		// reset leaves pins with the latches and the bus quiet
		cmp16("reset pad enables", 16'h000F, {12'h000, pin_oe});
		cmp16("reset pad levels", 16'h000F, {12'h000, pin_out});
		cmp16("reset mode", 16'h0000, mode_port);
		cmp1("reset rx", 1'h1, core_rx);
		cmp1("reset irq", 1'h0, irq);
		arst_n <= 1'h1;
		// ordinary pin usage, loopback and infrared cases
		foreach (rows[i])
		begin
			@(posedge clk_in);
			core_tx <= rows[i].tx;
			core_rts <= rows[i].rts;
			bclk <= rows[i].bclk;
			wr(`UMC_OFS_MODE, rows[i].mode);
			repeat (20) @(posedge clk_in);
			chk_rd("mode readback", `UMC_OFS_MODE, rows[i].mode);
			cmp16("pad enables", {12'h000, rows[i].oe}, {12'h000, pin_oe});
			cmp16("pad levels", {12'h000, rows[i].out}, {12'h000, pin_out & pin_oe});
			cmp1("cts to core", rows[i].cts, core_cts);
			if (rows[i].chk_rx)
				cmp1("rx to core", rows[i].rx, core_rx);
		end
		// unimplemented mode bits and unmapped addresses read zero
		wr(`UMC_OFS_MODE, 16'h4400);
		chk_rd("reserved mode bits", `UMC_OFS_MODE, 16'h0000);
		chk_rd("unmapped read", 8'h10, 16'h0000);
		// wake on start: masked event first, then unmasked and cleared
		wr(`UMC_OFS_MODE, 16'h8080);
		sleep <= 1'h1;
		i_remote.set_rx(1'h0);
		repeat (4) @(posedge clk_in);
		chk_rd("wake status", `UMC_OFS_STAT, 16'h0001);
		cmp1("masked irq", 1'h0, irq);
		chk_rd("wake bit held", `UMC_OFS_MODE, 16'h8080);
		i_remote.set_rx(1'h1);
		repeat (4) @(posedge clk_in);
		chk_rd("wake bit cleared", `UMC_OFS_MODE, 16'h8000);
		wr(`UMC_OFS_MASK, 16'h0003);
		cmp1("wake irq", 1'h1, irq);
		wr(`UMC_OFS_STAT, 16'h0001);
		cmp1("irq after clear", 1'h0, irq);
		sleep <= 1'h0;
		// auto baud over a 55h sync character
		wr(`UMC_OFS_MODE, 16'h8020);
		repeat (3) @(posedge clk_in);
		i_remote.send_byte(8'h55, BIT_CYC);
		repeat (4) @(posedge clk_in);
		cmp16("measured period", BIT_CYC, meas);
		cmp16("mode port", 16'h8000, mode_port);
		chk_rd("baud status", `UMC_OFS_STAT, 16'h0002);
		cmp1("baud irq", 1'h1, irq);
		wr(`UMC_OFS_MEAS, 16'h0000);
		chk_rd("measure read only", `UMC_OFS_MEAS, BIT_CYC);
		wr(`UMC_OFS_STAT, 16'h0002);
		cmp1("irq cleared", 1'h0, irq);
		conclude();
	end
endmodule // umc_mode_ctrl_tb
